// ---- design/swe_eeprom_slave.sv ----
// two-wire serial memory slave: 1024 x 8 array, page buffer, write timer
// assumes scl/sda/strap are asynchronous pins and AHB-Lite on hclk
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps

module swe_eeprom_slave #(
  parameter int         WRITE_CYCLES = swe_pkg::WRITE_CYCLES_DFLT,
  parameter logic [3:0] DEV_TYPE_ID  = 4'h6  // arbitrary value
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        device_select_strap
);

  // ****************************************************************
  // state, events and array
  // ****************************************************************
  swe_pkg::swe_regs_s st;
  swe_pkg::swe_regs_s nxt;

  // erased contents at power-up; no reset so it maps onto ram
  logic [7:0]  mem [0:swe_pkg::MEM_WORDS-1] = '{default: swe_pkg::ERASED_BYTE};
  logic        ev_rise;
  logic        ev_fall;
  logic        ev_start;
  logic        ev_stop;
  logic [7:0]  rd_byte;
  logic        commit;
  logic [9:0]  commit_addr;
  logic        byte_end;
  logic        dev_match;
  logic        load_evt;
  logic        store_evt;
  logic [31:0] status_word;

  // edges seen only after the two-stage synchronisers
  assign ev_rise  = st.scl_s2 & ~st.scl_q;
  assign ev_fall  = ~st.scl_s2 & st.scl_q;
  assign ev_start = st.scl_s2 & st.scl_q & st.sda_q & ~st.sda_s2;
  assign ev_stop  = st.scl_s2 & st.scl_q & ~st.sda_q & st.sda_s2;

  assign rd_byte     = mem[st.addr];
  assign byte_end    = (st.state == swe_pkg::S_RECV) && ev_fall && (st.cnt == 4'h8);
  assign dev_match   = (st.shreg[7:4] == DEV_TYPE_ID) && (st.shreg[3] == st.strap_s2);
  assign load_evt    = ev_fall && !ev_stop && !ev_start
                       && (((st.state == swe_pkg::S_ACK) && st.rw) || ((st.state == swe_pkg::S_MACK) && st.mack));
  assign store_evt   = byte_end && !ev_stop && !ev_start && (st.kind == swe_pkg::K_DATA);
  assign commit_addr = {st.page, st.bcnt[3:0]};
  // page is copied one byte per cycle at the start of the busy window
  assign commit      = st.busy && (st.bcnt < 20'(swe_pkg::PAGE_BYTES)) && st.pmask[st.bcnt[3:0]];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[swe_pkg::STAT_BUSY_BIT]   = st.busy;
    status_word[swe_pkg::STAT_ACTIVE_BIT] = (st.state != swe_pkg::S_IDLE);
    status_word[swe_pkg::STAT_ADDR_LSB +: swe_pkg::ADDR_W] = st.addr;
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    nxt = st;
    nxt.scl_s1   = scl_i;
    nxt.scl_s2   = st.scl_s1;
    nxt.scl_q    = st.scl_s2;
    nxt.sda_s1   = sda_i;
    nxt.sda_s2   = st.sda_s1;
    nxt.sda_q    = st.sda_s2;
    nxt.strap_s1 = device_select_strap;
    nxt.strap_s2 = st.strap_s1;
    nxt.sda_o    = 1'b0;

    // self-timed write window
    if (st.busy) begin
      nxt.bcnt = st.bcnt + 20'h00001;
      if (st.bcnt == 20'(WRITE_CYCLES - 1)) begin
        nxt.busy  = 1'b0;
        nxt.bcnt  = 20'h00000;
        nxt.pmask = 16'h0000;
      end
    end

    case (st.state)
      swe_pkg::S_IDLE: begin
        nxt.sda_oe = 1'b0;
      end
      swe_pkg::S_RECV: begin
        if (ev_rise && st.cnt != 4'h8) begin
          nxt.shreg = {st.shreg[6:0], st.sda_s2};
          nxt.cnt   = st.cnt + 4'h1;
        end else if (byte_end) begin
          nxt.state  = swe_pkg::S_ACK;
          nxt.sda_oe = 1'b1;
          case (st.kind)
            swe_pkg::K_DEV: begin
              if (dev_match) begin
                nxt.rw = st.shreg[0];
                if (!st.shreg[0]) begin
                  nxt.addr[9:8] = st.shreg[2:1];
                end
                nxt.kind = swe_pkg::K_WORD;
              end else begin
                nxt.state  = swe_pkg::S_IGNORE;
                nxt.sda_oe = 1'b0;
              end
            end
            swe_pkg::K_WORD: begin
              nxt.addr = {st.addr[9:8], st.shreg};
              nxt.kind = swe_pkg::K_DATA;
            end
            swe_pkg::K_DATA: begin
              nxt.pbuf[st.addr[3:0]]  = st.shreg;
              nxt.pmask[st.addr[3:0]] = 1'b1;
              nxt.addr[3:0]           = st.addr[3:0] + 4'h1;
              nxt.wpend               = 1'b1;
            end
            default: begin
              nxt.state  = swe_pkg::S_IGNORE;
              nxt.sda_oe = 1'b0;
            end
          endcase
        end
      end
      swe_pkg::S_ACK: begin
        if (ev_fall) begin
          nxt.sda_oe = 1'b0;
          nxt.cnt    = 4'h0;
          nxt.state  = swe_pkg::S_RECV;
          if (st.rw) begin
            nxt.shreg  = rd_byte;
            nxt.sda_oe = ~rd_byte[7];
            nxt.addr   = st.addr + 10'h001;
            nxt.state  = swe_pkg::S_SEND;
          end
        end
      end
      swe_pkg::S_SEND: begin
        if (ev_fall) begin
          if (st.cnt != 4'h7) begin
            nxt.shreg  = {st.shreg[6:0], 1'b0};
            nxt.sda_oe = ~st.shreg[6];
            nxt.cnt    = st.cnt + 4'h1;
          end else begin
            nxt.sda_oe = 1'b0;
            nxt.mack   = 1'b0;
            nxt.state  = swe_pkg::S_MACK;
          end
        end
      end
      swe_pkg::S_MACK: begin
        if (ev_rise) begin
          nxt.mack = ~st.sda_s2;
        end else if (ev_fall) begin
          if (st.mack) begin
            nxt.shreg  = rd_byte;
            nxt.sda_oe = ~rd_byte[7];
            nxt.addr   = st.addr + 10'h001;
            nxt.cnt    = 4'h0;
            nxt.state  = swe_pkg::S_SEND;
          end else begin
            nxt.state = swe_pkg::S_IGNORE;
          end
        end
      end
      swe_pkg::S_IGNORE: begin
        nxt.sda_oe = 1'b0;
      end
      default: begin
        nxt.state  = swe_pkg::S_IDLE;
        nxt.sda_oe = 1'b0;
      end
    endcase

    // bus conditions override any bit-level step
    if (ev_stop) begin
      nxt.state  = swe_pkg::S_IDLE;
      nxt.sda_oe = 1'b0;
      if (st.wpend && !st.busy) begin
        nxt.busy  = 1'b1;
        nxt.bcnt  = 20'h00000;
        nxt.page  = st.addr[9:4];
        nxt.wpend = 1'b0;
      end
    end else if (ev_start && !st.busy && st.ctrl_en) begin
      // busy or disabled: start is not seen, so polling gets no ack
      nxt.state  = swe_pkg::S_RECV;
      nxt.kind   = swe_pkg::K_DEV;
      nxt.cnt    = 4'h0;
      nxt.sda_oe = 1'b0;
      nxt.wpend  = 1'b0;
      nxt.pmask  = 16'h0000;
    end else if (st.busy) begin
      nxt.state  = swe_pkg::S_IDLE;
      nxt.sda_oe = 1'b0;
    end

    // ahb-lite slave, zero wait states, always okay
    nxt.ahb.hreadyout = 1'b1;
    nxt.ahb.hresp     = 1'b0;
    nxt.ahb.wr_pend   = 1'b0;
    if (st.ahb.wr_pend && st.ahb.wr_addr == swe_pkg::REG_CTRL_OFS) begin
      nxt.ctrl_en = hwdata[swe_pkg::CTRL_EN_BIT];
    end
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        nxt.ahb.wr_pend = 1'b1;
        nxt.ahb.wr_addr = haddr[11:0];
      end else if (haddr[11:0] == swe_pkg::REG_CTRL_OFS) begin
        nxt.ahb.rdata = {31'h0000_0000, st.ctrl_en};
      end else if (haddr[11:0] == swe_pkg::REG_STATUS_OFS) begin
        nxt.ahb.rdata = status_word;
      end else begin
        nxt.ahb.rdata = 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st               <= '0;
      st.scl_s1        <= 1'b1;
      st.scl_s2        <= 1'b1;
      st.scl_q         <= 1'b1;
      st.sda_s1        <= 1'b1;
      st.sda_s2        <= 1'b1;
      st.sda_q         <= 1'b1;
      st.state         <= swe_pkg::S_IDLE;
      st.kind          <= swe_pkg::K_DEV;
      st.ctrl_en       <= swe_pkg::CTRL_EN_RESET;
      st.ahb.hreadyout <= 1'b1;
    end else begin
      st <= nxt;
    end
  end

  always_ff @(posedge hclk) begin
    if (commit) begin
      mem[commit_addr] <= st.pbuf[st.bcnt[3:0]];
    end
  end

  assign hreadyout = st.ahb.hreadyout;
  assign hresp     = st.ahb.hresp;
  assign hrdata    = st.ahb.rdata;
  assign sda_o     = st.sda_o;
  assign sda_oe    = st.sda_oe;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_dev_byte;
    byte_end && !ev_stop && !ev_start && (st.kind == swe_pkg::K_DEV);
  endsequence

  sequence seq_nack_seen;
    (st.state == swe_pkg::S_MACK) && ev_fall && !st.mack && !ev_stop && !ev_start;
  endsequence

  a_start_listens: assert property (ev_start && !st.busy && st.ctrl_en && !ev_stop
    |=> st.state == swe_pkg::S_RECV && st.cnt == 4'h0 && !st.sda_oe)
    else $error("start not followed by address reception");

  a_match_acks: assert property (seq_dev_byte and dev_match
    |=> st.sda_oe && st.state == swe_pkg::S_ACK)
    else $error("matching address not acknowledged");

  a_mismatch_quiet: assert property (seq_dev_byte and !dev_match
    |=> st.state == swe_pkg::S_IGNORE && !st.sda_oe)
    else $error("mismatching address drove the data line");

  a_busy_deaf: assert property (st.busy && !$rose(st.busy)
    |-> st.state == swe_pkg::S_IDLE && !st.sda_oe)
    else $error("device active during internal write");

  a_stop_commits: assert property (ev_stop && st.wpend && !st.busy
    |=> st.busy [*8])
    else $error("stop after write data did not start internal write");

  a_busy_ends: assert property (st.busy && st.bcnt == 20'(WRITE_CYCLES - 1)
    |=> !st.busy && st.bcnt == 20'h00000)
    else $error("internal write length wrong");

  a_page_wrap: assert property (store_evt
    |=> st.addr[9:4] == $past(st.addr[9:4]) && st.addr[3:0] == $past(st.addr[3:0]) + 4'h1
        && st.wpend)
    else $error("page write address step wrong");

  a_read_step: assert property (load_evt
    |=> st.addr == $past(st.addr) + 10'h001 && st.sda_oe == ~$past(rd_byte[7]))
    else $error("read address or first bit wrong");

  a_ack_release: assert property ((st.state == swe_pkg::S_ACK) && ev_fall && !st.rw && !ev_start
    |=> !st.sda_oe ##1 !st.sda_oe)
    else $error("acknowledge held past ninth clock");

  a_nack_stops: assert property (seq_nack_seen
    |=> st.state == swe_pkg::S_IGNORE && !st.sda_oe)
    else $error("transmission continued without acknowledge");

  a_data_on_low: assert property ($changed(st.sda_oe)
    |-> $past(ev_fall || ev_start || ev_stop || st.busy || byte_end))
    else $error("data line changed outside a low clock");

  a_idle_released: assert property ((st.state == swe_pkg::S_IDLE)
    |-> !st.sda_oe)
    else $error("data line held while idle");

  a_stop_idles: assert property (ev_stop
    |=> st.state == swe_pkg::S_IDLE && !st.sda_oe)
    else $error("stop did not return to idle");

  a_ignore_quiet: assert property ((st.state == swe_pkg::S_IGNORE)
    |-> !st.sda_oe)
    else $error("data line driven while ignoring the bus");

  a_rw_select: assert property (seq_dev_byte and dev_match
    |=> st.rw == $past(st.shreg[0]))
    else $error("direction bit not taken from address byte");

  a_upper_bits: assert property (seq_dev_byte and dev_match && !st.shreg[0]
    |=> st.addr[9:8] == $past(st.shreg[2:1]))
    else $error("array bits not taken from address byte");

  a_word_load: assert property (byte_end && !ev_stop && !ev_start && (st.kind == swe_pkg::K_WORD)
    |=> st.addr[7:0] == $past(st.shreg) && st.addr[9:8] == $past(st.addr[9:8]) && st.sda_oe)
    else $error("word address not loaded or not acknowledged");

  a_data_acked: assert property (store_evt
    |=> st.state == swe_pkg::S_ACK && st.sda_oe)
    else $error("write data byte not acknowledged");

  a_start_clears: assert property (ev_start && !st.busy && st.ctrl_en
    |=> !st.wpend && st.pmask == 16'h0000 && st.kind == swe_pkg::K_DEV)
    else $error("start left stale write state");

  a_poll_silent: assert property (ev_start && st.busy
    |=> st.state == swe_pkg::S_IDLE && !st.sda_oe)
    else $error("start seen during internal write");

  a_busy_window: assert property ($rose(st.busy)
    |-> st.bcnt == 20'h00000 && st.page == st.addr[9:4])
    else $error("internal write started with wrong page or count");

  a_mack_sample: assert property ((st.state == swe_pkg::S_MACK) && ev_rise
    |=> st.mack == ~$past(st.sda_s2))
    else $error("master acknowledge sampled wrong");

  a_mack_released: assert property ((st.state == swe_pkg::S_MACK)
    |-> !st.sda_oe)
    else $error("data line held in master acknowledge slot");

  a_send_shift: assert property ((st.state == swe_pkg::S_SEND) && ev_fall && (st.cnt != 4'h7)
    |=> st.sda_oe == ~$past(st.shreg[6]) && st.cnt == $past(st.cnt) + 4'h1)
    else $error("read bit not shifted on low clock");

  sequence seq_byte_sent;
    (st.state == swe_pkg::S_SEND) && ev_fall && (st.cnt == 4'h7);
  endsequence

  a_byte_release: assert property (seq_byte_sent
    |=> st.state == swe_pkg::S_MACK && !st.sda_oe && !st.mack)
    else $error("data line not released after eight bits");

endmodule

// ---- include/swe_pkg.sv ----
// shared constants and types for the two-wire serial memory slave
// assumes a 200 MHz hclk, an AHB-Lite master and open-drain pads outside
//
// Notes on behaviour
// - data moves only while clock is low; high-clock data edges are start/stop
// - device watches for start and ignores everything until one is seen
// - every transfer ends with stop; stop returns the device to standby
// - after eight bits transmitter releases; receiver pulls low in ninth clock
// - slave address compared with type code and strap; match acks, then read/write
// - top four address bits must equal the fixed device-type code
// - fifth address bit must equal the select strap level
// - on write, next two address bits become the upper two of the ten-bit location; a read keeps the counter
// - last address bit one means read, zero means write
// - once selected for write, every received byte is acknowledged
// - byte write: word address then one data byte, both acknowledged
// - stop after write data starts the self-timed internal write
// - during the internal write the device ignores the bus entirely
// - page write takes up to sixteen data bytes, each acknowledged
// - each written byte bumps only the low four address bits
// - more than sixteen bytes wrap within the page and overwrite
// - read: send eight bits, release, sample ack, continue while acked
// - no ack ends transmission; master then issues stop
// - polling: address not acked while busy, acked once write completes
// - address counter holds last accessed location plus one
// - read counter increments all ten bits and wraps to zero

package swe_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int T_WRITE_MS        = 5;
  localparam int CLK_MHZ           = 200;
  localparam int WRITE_CYCLES_DFLT = T_WRITE_MS * 1000 * CLK_MHZ;
  localparam int BUSY_CNT_W        = 20;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int ADDR_W     = 10;
  localparam int MEM_WORDS  = 1024;
  localparam int PAGE_BYTES = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] REG_CTRL_OFS   = 12'h000;
  localparam logic [11:0] REG_STATUS_OFS = 12'h004;
  localparam int CTRL_EN_BIT     = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_ADDR_LSB   = 8;

  typedef enum logic [1:0] {K_DEV, K_WORD, K_DATA} swe_kind_e;
  typedef enum logic [2:0] {S_IDLE, S_RECV, S_ACK, S_SEND, S_MACK, S_IGNORE} swe_state_e;

  typedef struct packed {
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic        hreadyout;
    logic        hresp;
  } swe_ahb_s;

  typedef struct packed {
    logic               scl_s1;
    logic               scl_s2;
    logic               scl_q;
    logic               sda_s1;
    logic               sda_s2;
    logic               sda_q;
    logic               strap_s1;
    logic               strap_s2;
    swe_state_e         state;
    swe_kind_e          kind;
    logic [3:0]         cnt;
    logic [7:0]         shreg;
    logic               rw;
    logic               mack;
    logic [9:0]         addr;
    logic [15:0][7:0]   pbuf;
    logic [15:0]        pmask;
    logic               wpend;
    logic [5:0]         page;
    logic               busy;
    logic [19:0]        bcnt;
    logic               sda_oe;
    logic               sda_o;
    logic               ctrl_en;
    swe_ahb_s           ahb;
  } swe_regs_s;

endpackage

// ---- dv/swe_tw_master.sv ----
// two-wire bus master model: drives the serial clock and opens every frame
// assumes the data wire is resolved outside from both open-drain pulls with a pull-up
`timescale 1ns/1ps

module swe_tw_master (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // ****************************************************************
  // bit and frame tasks, 160 ns clock only inside frames
  // ****************************************************************
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic put_bit(input logic b);
    sda_pull = !b;  // data moves only while clock is low
    #40 scl = 1'b1;
    #80 scl = 1'b0;
    #40;
  endtask

  task automatic get_bit(output logic b);
    sda_pull = 1'b0;  // let go so the other side can drive
    #40 scl = 1'b1;
    #40 b = sda;
    #40 scl = 1'b0;
    #40;
  endtask

  task automatic start();
    if (scl === 1'b0) begin
      sda_pull = 1'b0;
      #40 scl = 1'b1;
      #40;
    end
    sda_pull = 1'b1;  // master opens every transfer and owns the clock
    #40 scl = 1'b0;
    #40;
  endtask

  task automatic stop();
    sda_pull = 1'b1;  // only after the transmitter has let go
    #40 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #80;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = !b;
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(!mack);  // ack in the ninth clock, nack ends the read
  endtask
endmodule

// ---- dv/swe_eeprom_slave_tb.sv ----
// self-checking bench: AHB-Lite register master plus two-wire master model
// assumes the slave answers at once on AHB and a shortened write timer
`timescale 1ns/1ps

module swe_eeprom_slave_tb;
  // ****************************************************************
  // setup
  // ****************************************************************
  localparam logic [3:0]  DEV    = 4'h6;  // arbitrary type code
  localparam logic [31:0] A_CTRL = {20'h00000, swe_pkg::REG_CTRL_OFS};
  localparam logic [31:0] A_STAT = {20'h00000, swe_pkg::REG_STATUS_OFS};
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        scl, sda_w, sda_o, sda_oe, strap, m_pull, ack;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] lfsr;
  logic [9:0]  wa, wb;
  logic [7:0]  ab;
  logic [7:0]  mem [1024];
  int          n_fail, checked;

  assign hready = hreadyout;
  assign sda_w  = !((sda_oe && !sda_o) || m_pull);  // open drain with pull-up

  swe_eeprom_slave #(.WRITE_CYCLES(600), .DEV_TYPE_ID(DEV)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .device_select_strap(strap));
  swe_tw_master u_mst (.scl(scl), .sda_pull(m_pull), .sda(sda_w));

  function automatic logic [15:0] lfsr_nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] dev_byte(input logic r, input logic [1:0] hi);
    return {DEV, strap, hi, r};  // type, strap, array bits, direction
  endfunction

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ends off the hclk edge so the 40 ns serial steps never meet a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
    #1.3;
  endtask

  task automatic wr_page(input logic [9:0] a, input int n);
    logic [7:0]  d;
    logic [31:0] r;
    int          t;
    u_mst.start();
    u_mst.wbyte(dev_byte(1'b0, a[9:8]), ack);
    chk(ack === 1'b1, "address ack");
    u_mst.wbyte(a[7:0], ack);
    chk(ack === 1'b1, "word ack");
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_nxt(lfsr);
      d = lfsr[7:0];
      u_mst.wbyte(d, ack);
      chk(ack === 1'b1, "data ack");
      mem[{a[9:4], a[3:0] + i[3:0]}] = d;  // low four bits wrap in the page
    end
    ahb(1'b0, A_STAT, 32'h0, r);
    chk(r[1] === 1'b1, "active inside frame");
    u_mst.stop();
    repeat (10) @(posedge hclk);
    ahb(1'b0, A_STAT, 32'h0, r);
    chk(r[0] === 1'b1, "busy after stop");
    t = 0;
    ack = 1'b0;
    while (ack !== 1'b1 && t < 20) begin
      u_mst.start();
      u_mst.wbyte(dev_byte(1'b0, 2'b00), ack);
      u_mst.stop();
      if (t == 0) begin
        chk(ack === 1'b0, "ack while busy");
      end
      t++;
    end
    chk(ack === 1'b1, "ack after write");
    ahb(1'b0, A_STAT, 32'h0, r);
    chk(r[0] === 1'b0, "busy cleared");
  endtask

  task automatic rd_seq(input logic cur, input logic [9:0] a, input int n);
    logic [7:0] d;
    if (!cur) begin
      u_mst.start();
      u_mst.wbyte(dev_byte(1'b0, a[9:8]), ack);
      u_mst.wbyte(a[7:0], ack);  // dummy write then repeated start
    end
    u_mst.start();
    u_mst.wbyte(dev_byte(1'b1, 2'b00), ack);
    chk(ack === 1'b1, "read address ack");
    for (int i = 0; i < n; i++) begin
      u_mst.rbyte(i < n - 1, d);
      chk(d === mem[a + i[9:0]], "read data");
    end
    u_mst.stop();
    chk(sda_oe === 1'b0, "released after stop");
  endtask

  // ****************************************************************
  // clock, sequence, watchdog
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    #300000;
    n_fail++;
    test_done();
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    lfsr = 16'h005F;
    strap = lfsr[0];
    n_fail = 0;
    checked = 0;
    foreach (mem[i]) mem[i] = swe_pkg::ERASED_BYTE;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(hreadyout === 1'b1 && hresp === 1'b0 && sda_oe === 1'b0 && sda_o === 1'b0, "idle outputs");
    ahb(1'b0, A_CTRL, 32'h0, rd);
    chk(rd === 32'h1, "ctrl reset");
    ahb(1'b1, A_STAT, 32'hFFFF_FFFF, rd);
    ahb(1'b0, A_STAT, 32'h0, rd);
    chk(rd[1:0] === 2'b00, "status idle");
    ahb(1'b0, 32'h0000_0010, 32'h0, rd);
    chk(rd === 32'h0, "unmapped read");
    for (int k = 0; k < 2; k++) begin
      ab = dev_byte(1'b0, 2'b00);
      if (k == 0) ab[7:4] = ~DEV;
      else ab[3] = !strap;
      u_mst.start();
      u_mst.wbyte(ab, ack);
      u_mst.stop();
      chk(ack === 1'b0, "ack on mismatch");
    end
    lfsr = lfsr_nxt(lfsr);
    wa = lfsr[9:0];
    wr_page(wa, 1);
    lfsr = lfsr_nxt(lfsr);
    wb = lfsr[9:0];
    wr_page(wb, 18);
    rd_seq(1'b0, wa, 1);
    rd_seq(1'b0, {wb[9:4], 4'h0}, 16);
    rd_seq(1'b0, 10'h3FF, 2);
    rd_seq(1'b1, 10'h001, 1);
    ahb(1'b0, A_STAT, 32'h0, rd);
    chk(rd[17:8] === 10'h002, "address counter");
    ahb(1'b1, A_CTRL, 32'h0, rd);
    ahb(1'b0, A_CTRL, 32'h0, rd);
    chk(rd === 32'h0, "ctrl cleared");
    u_mst.start();
    u_mst.wbyte(dev_byte(1'b0, 2'b00), ack);
    u_mst.stop();
    chk(ack === 1'b0, "ack while disabled");
    ahb(1'b1, A_CTRL, 32'h1, rd);
    test_done();
  end
endmodule
